/* File: hdl/acal_consts.vh */
// Register map, field positions and reset values of the calibration control block.
`ifndef ACAL_CONSTS_VH
`define ACAL_CONSTS_VH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define ACAL_IDX_CAL_EN      10'h061
`define ACAL_IDX_MODE_CFG    10'h062
`define ACAL_IDX_PARK_SEL    10'h064
`define ACAL_IDX_AVG         10'h068
`define ACAL_IDX_STATUS      10'h06A
`define ACAL_IDX_PIN_CFG     10'h06B
`define ACAL_IDX_IRQ_STS     10'h070
`define ACAL_IDX_IRQ_CLR     10'h071
`define ACAL_IDX_IRQ_EN      10'h072

// ****************************************************************
// Reset values
// ****************************************************************
`define ACAL_RST_CAL_EN      1'h1
`define ACAL_RST_MODE_CFG    8'h01
`define ACAL_RST_PARK_SEL    8'h02
`define ACAL_RST_AVG         8'h61
`define ACAL_RST_PIN_CFG     8'h00
`define ACAL_RST_IRQ_EN      2'h0

// ****************************************************************
// Field positions
// ****************************************************************
`define ACAL_BIT_CAL_EN      0
`define ACAL_BIT_BG_OFS      3
`define ACAL_BIT_FG_OFS      2
`define ACAL_BIT_BG          1
`define ACAL_BIT_FG          0
`define ACAL_PARK_HI         1
`define ACAL_PARK_LO         0
`define ACAL_OFS_AVG_HI      6
`define ACAL_OFS_AVG_LO      4
`define ACAL_LIN_AVG_HI      2
`define ACAL_LIN_AVG_LO      0
`define ACAL_BIT_FG_CMPL     0
`define ACAL_BIT_STOPPED     1

// ****************************************************************
// Field encodings and bus answers
// ****************************************************************
`define ACAL_PARK_CORE0      2'h0
`define ACAL_PARK_CORE1      2'h1
`define ACAL_PARK_CORE2      2'h2
`define ACAL_RESP_OKAY       2'h0
`define ACAL_RESP_SLVERR     2'h2

`endif

/* File: hdl/acal_ctrl.v */
// Calibration configuration and status block with an AXI4-Lite register slave.
`timescale 1ns/1ps
`include "acal_consts.vh"

module acal_ctrl (
    input  wire        REF_CLK,
    input  wire        RST_N,
    input  wire [11:0] AWADDR,
    input  wire        AWVALID,
    output wire        AWREADY,
    input  wire [31:0] WDATA,
    input  wire [3:0]  WSTRB,
    input  wire        WVALID,
    output wire        WREADY,
    output wire [1:0]  BRESP,
    output wire        BVALID,
    input  wire        BREADY,
    input  wire [11:0] ARADDR,
    input  wire        ARVALID,
    output wire        ARREADY,
    output wire [31:0] RDATA,
    output wire [1:0]  RRESP,
    output wire        RVALID,
    input  wire        RREADY,
    input  wire        ENG_FG_END,
    input  wire        ENG_BG_HALTED,
    output wire        ENG_RST_N,
    output wire        CAL_VALUES_CLR,
    output wire        FG_RUN,
    output wire        FG_OFFSET_RUN,
    output wire        BG_RUN,
    output wire        BG_OFFSET_RUN,
    output wire [2:0]  CORE_PARKED,
    output wire [2:0]  OFFSET_AVG,
    output wire [2:0]  LINEARITY_AVG,
    output wire        IRQ
);

    // ****************************************************************
    // Calibration sequencer states
    // ****************************************************************
    localparam [4:0] S_HOLD = 5'h01;
    localparam [4:0] S_CLR  = 5'h02;
    localparam [4:0] S_FG   = 5'h04;
    localparam [4:0] S_BG   = 5'h08;
    localparam [4:0] S_PARK = 5'h10;

    reg        awready_ff, wready_ff, aw_got_ff, w_got_ff, wstrb_ff, bvalid_ff;
    reg        arready_ff, rvalid_ff, cal_en_ff, irq_ff, rd_hit, wr_hit;
    reg        fg_cmpl_ff, stopped_ff, nxt_fg_cmpl, nxt_stopped;
    reg        eng_rst_n_ff, clr_ff, fg_run_ff, fg_ofs_ff, bg_run_ff, bg_ofs_ff;
    reg [1:0]  bresp_ff, rresp_ff, irq_sts_ff, irq_en_ff, nxt_irq_sts;
    reg [2:0]  parked_ff, stat_code, nxt_parked;
    reg [4:0]  state_ff, nxt_state;
    reg [7:0]  wdata_ff, mode_cfg_ff, park_sel_ff, avg_ff, pin_cfg_ff, rd_val;
    reg [9:0]  aw_idx_ff;
    reg [31:0] rdata_ff;

    wire       do_write, bg_en, fg_en;
    wire [1:0] irq_evt;

    assign bg_en    = mode_cfg_ff[`ACAL_BIT_BG];
    assign fg_en    = mode_cfg_ff[`ACAL_BIT_FG];
    assign do_write = aw_got_ff & w_got_ff & ~bvalid_ff;

    // ****************************************************************
    // AXI4-Lite write path
    // ****************************************************************
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            aw_idx_ff  <= 10'h000;
            wdata_ff   <= 8'h00;
            wstrb_ff   <= 1'b0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= `ACAL_RESP_OKAY;
        end else begin
            awready_ff <= ~aw_got_ff & ~(AWVALID & awready_ff) & ~bvalid_ff;
            wready_ff  <= ~w_got_ff & ~(WVALID & wready_ff) & ~bvalid_ff;
            if (AWVALID && awready_ff) begin
                aw_got_ff <= 1'b1;
                aw_idx_ff <= AWADDR[11:2];
            end
            if (WVALID && wready_ff) begin
                w_got_ff <= 1'b1;
                wdata_ff <= WDATA[7:0];
                wstrb_ff <= WSTRB[0];
            end
            if (do_write) begin
                aw_got_ff <= 1'b0;
                w_got_ff  <= 1'b0;
                bvalid_ff <= 1'b1;
                bresp_ff  <= wr_hit ? `ACAL_RESP_OKAY : `ACAL_RESP_SLVERR;
            end else if (bvalid_ff && BREADY) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // Status is decoded as mapped so a write there answers OKAY but stores nothing.
    always @* begin
        case (aw_idx_ff)
            `ACAL_IDX_CAL_EN, `ACAL_IDX_MODE_CFG, `ACAL_IDX_PARK_SEL,
            `ACAL_IDX_AVG, `ACAL_IDX_STATUS, `ACAL_IDX_PIN_CFG,
            `ACAL_IDX_IRQ_STS, `ACAL_IDX_IRQ_CLR, `ACAL_IDX_IRQ_EN: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            cal_en_ff   <= `ACAL_RST_CAL_EN;
            mode_cfg_ff <= `ACAL_RST_MODE_CFG;
            park_sel_ff <= `ACAL_RST_PARK_SEL;
            avg_ff      <= `ACAL_RST_AVG;
            pin_cfg_ff  <= `ACAL_RST_PIN_CFG;
            irq_en_ff   <= `ACAL_RST_IRQ_EN;
        end else if (do_write && wstrb_ff) begin
            case (aw_idx_ff)
                `ACAL_IDX_CAL_EN:   cal_en_ff   <= wdata_ff[`ACAL_BIT_CAL_EN];
                `ACAL_IDX_MODE_CFG: mode_cfg_ff <= wdata_ff;
                `ACAL_IDX_PARK_SEL: park_sel_ff <= wdata_ff;
                `ACAL_IDX_AVG:      avg_ff      <= wdata_ff;
                `ACAL_IDX_PIN_CFG:  pin_cfg_ff  <= wdata_ff;
                `ACAL_IDX_IRQ_EN:   irq_en_ff   <= wdata_ff[1:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Calibration sequencer
    // ****************************************************************
    always @* begin
        nxt_state   = state_ff;
        nxt_fg_cmpl = fg_cmpl_ff;
        nxt_stopped = stopped_ff;
        case (state_ff)
            S_HOLD: begin
                nxt_fg_cmpl = 1'b0;
                nxt_stopped = 1'b0;
                if (cal_en_ff)
                    nxt_state = S_CLR;
            end
            S_CLR: begin
                if (fg_en)
                    nxt_state = S_FG;
                else begin
                    nxt_fg_cmpl = 1'b1;
                    nxt_stopped = ~bg_en;
                    nxt_state   = bg_en ? S_BG : S_PARK;
                end
            end
            S_FG: begin
                if (ENG_FG_END) begin
                    nxt_fg_cmpl = 1'b1;
                    nxt_stopped = ~bg_en;
                    nxt_state   = bg_en ? S_BG : S_PARK;
                end
            end
            S_BG: begin
                nxt_stopped = ENG_BG_HALTED;
                if (!bg_en) begin
                    nxt_stopped = 1'b1;
                    nxt_state   = S_PARK;
                end
            end
            S_PARK: begin
                nxt_stopped = 1'b1;
                if (bg_en) begin
                    nxt_stopped = 1'b0;
                    nxt_state   = S_BG;
                end
            end
            default: nxt_state = S_HOLD;
        endcase
        if (!cal_en_ff)
            nxt_state = S_HOLD;
    end

    // Parked core decode; the reserved code parks nothing.
    always @* begin
        nxt_parked = 3'h0;
        if (nxt_state == S_PARK) begin
            case (park_sel_ff[`ACAL_PARK_HI:`ACAL_PARK_LO])
                `ACAL_PARK_CORE0: nxt_parked = 3'h1;
                `ACAL_PARK_CORE1: nxt_parked = 3'h2;
                `ACAL_PARK_CORE2: nxt_parked = 3'h4;
                default:          nxt_parked = 3'h0;
            endcase
        end
    end

    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            state_ff     <= S_HOLD;
            fg_cmpl_ff   <= 1'b0;
            stopped_ff   <= 1'b0;
            eng_rst_n_ff <= 1'b0;
            clr_ff       <= 1'b0;
            fg_run_ff    <= 1'b0;
            fg_ofs_ff    <= 1'b0;
            bg_run_ff    <= 1'b0;
            bg_ofs_ff    <= 1'b0;
            parked_ff    <= 3'h0;
        end else begin
            state_ff     <= nxt_state;
            fg_cmpl_ff   <= nxt_fg_cmpl;
            stopped_ff   <= nxt_stopped;
            eng_rst_n_ff <= (nxt_state != S_HOLD);
            clr_ff       <= (nxt_state == S_CLR);
            fg_run_ff    <= (nxt_state == S_FG);
            fg_ofs_ff    <= (nxt_state == S_FG) & mode_cfg_ff[`ACAL_BIT_FG_OFS];
            bg_run_ff    <= (nxt_state == S_BG);
            bg_ofs_ff    <= (nxt_state == S_BG) & bg_en
                            & mode_cfg_ff[`ACAL_BIT_BG_OFS];
            parked_ff    <= nxt_parked;
        end
    end

    // ****************************************************************
    // Interrupt status, clear and enable
    // ****************************************************************
    assign irq_evt = {nxt_stopped & ~stopped_ff, nxt_fg_cmpl & ~fg_cmpl_ff};

    // A new event in the cycle of its clear keeps the bit set.
    always @* begin
        nxt_irq_sts = irq_sts_ff;
        if (do_write && wstrb_ff && aw_idx_ff == `ACAL_IDX_IRQ_CLR)
            nxt_irq_sts = irq_sts_ff & ~wdata_ff[1:0];
        nxt_irq_sts = nxt_irq_sts | irq_evt;
    end

    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            irq_sts_ff <= 2'h0;
            irq_ff     <= 1'b0;
        end else begin
            irq_sts_ff <= nxt_irq_sts;
            irq_ff     <= |(nxt_irq_sts & irq_en_ff);
        end
    end

    // ****************************************************************
    // AXI4-Lite read path
    // ****************************************************************
    always @* begin
        case (state_ff)
            S_CLR:   stat_code = 3'h1;
            S_FG:    stat_code = 3'h2;
            S_BG:    stat_code = 3'h3;
            S_PARK:  stat_code = 3'h4;
            default: stat_code = 3'h0;
        endcase
    end

    always @* begin
        rd_hit = 1'b1;
        case (ARADDR[11:2])
            `ACAL_IDX_CAL_EN:   rd_val = {7'h00, cal_en_ff};
            `ACAL_IDX_MODE_CFG: rd_val = mode_cfg_ff;
            `ACAL_IDX_PARK_SEL: rd_val = park_sel_ff;
            `ACAL_IDX_AVG:      rd_val = avg_ff;
            `ACAL_IDX_STATUS:   rd_val = {3'h0, stat_code, stopped_ff, fg_cmpl_ff};
            `ACAL_IDX_PIN_CFG:  rd_val = pin_cfg_ff;
            `ACAL_IDX_IRQ_STS:  rd_val = {6'h00, irq_sts_ff};
            `ACAL_IDX_IRQ_CLR:  rd_val = 8'h00;
            `ACAL_IDX_IRQ_EN:   rd_val = {6'h00, irq_en_ff};
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    always @(posedge REF_CLK) begin
        if (!RST_N) begin
            arready_ff <= 1'b0;
            rvalid_ff  <= 1'b0;
            rdata_ff   <= 32'h0000_0000;
            rresp_ff   <= `ACAL_RESP_OKAY;
        end else begin
            arready_ff <= ~rvalid_ff & ~(ARVALID & arready_ff);
            if (ARVALID && arready_ff) begin
                rvalid_ff <= 1'b1;
                rdata_ff  <= {24'h00_0000, rd_val};
                rresp_ff  <= rd_hit ? `ACAL_RESP_OKAY : `ACAL_RESP_SLVERR;
            end else if (rvalid_ff && RREADY) begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    assign AWREADY        = awready_ff;
    assign WREADY         = wready_ff;
    assign BVALID         = bvalid_ff;
    assign BRESP          = bresp_ff;
    assign ARREADY        = arready_ff;
    assign RVALID         = rvalid_ff;
    assign RDATA          = rdata_ff;
    assign RRESP          = rresp_ff;
    assign ENG_RST_N      = eng_rst_n_ff;
    assign CAL_VALUES_CLR = clr_ff;
    assign FG_RUN         = fg_run_ff;
    assign FG_OFFSET_RUN  = fg_ofs_ff;
    assign BG_RUN         = bg_run_ff;
    assign BG_OFFSET_RUN  = bg_ofs_ff;
    assign CORE_PARKED    = parked_ff;
    assign OFFSET_AVG     = avg_ff[`ACAL_OFS_AVG_HI:`ACAL_OFS_AVG_LO];
    assign LINEARITY_AVG  = avg_ff[`ACAL_LIN_AVG_HI:`ACAL_LIN_AVG_LO];
    assign IRQ            = irq_ff;

endmodule

/* File: tb/acal_ctrl_monitor.sv */
// Concurrent checks on the ports of the calibration control block.
`timescale 1ns/1ps
module acal_ctrl_monitor (
    input logic       REF_CLK,
    input logic       RST_N,
    input logic       ENG_FG_END,
    input logic       ENG_RST_N,
    input logic       CAL_VALUES_CLR,
    input logic       FG_RUN,
    input logic       FG_OFFSET_RUN,
    input logic       BG_RUN,
    input logic       BG_OFFSET_RUN,
    input logic [2:0] CORE_PARKED,
    input logic [2:0] OFFSET_AVG,
    input logic [2:0] LINEARITY_AVG
);
    // ****************************************************************
    // Sequencer and field checks
    // ****************************************************************
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    sequence s_fg_end;
        FG_RUN && ENG_FG_END;
    endsequence

    sequence s_start;
        $rose(ENG_RST_N);
    endsequence

    a_clr_pulse: assert property (CAL_VALUES_CLR |=> !CAL_VALUES_CLR)
        else $error("values clear lasted more than one cycle");
    a_start_clr: assert property (s_start |-> CAL_VALUES_CLR)
        else $error("start without values clear");
    a_fg_after_clr: assert property ($rose(FG_RUN) |-> $past(CAL_VALUES_CLR))
        else $error("foreground run without preceding clear");
    a_fg_exit: assert property (s_fg_end |=> !FG_RUN)
        else $error("foreground run stayed after done");
    a_fg_exit_cause: assert property ($fell(FG_RUN) && ENG_RST_N |-> $past(ENG_FG_END))
        else $error("foreground run ended without done");
    a_fg_ofs_sub: assert property (FG_OFFSET_RUN |-> FG_RUN)
        else $error("foreground offset without foreground run");
    a_bg_ofs_sub: assert property (BG_OFFSET_RUN |-> BG_RUN)
        else $error("background offset without background run");
    a_park_excl: assert property (CORE_PARKED != 3'h0 |-> $onehot(CORE_PARKED) && !BG_RUN)
        else $error("parked core not one-hot or background running");
    a_held_quiet: assert property (!ENG_RST_N |-> !FG_RUN && !BG_RUN && CORE_PARKED == 3'h0)
        else $error("activity while engine held");
    a_avg_reset: assert property ($rose(RST_N) |-> OFFSET_AVG == 3'h6 && LINEARITY_AVG == 3'h1)
        else $error("averaging outputs wrong after reset");
endmodule

/* File: tb/tb_adc_calibration_config_status.sv */
// Self-checking bench for the calibration configuration and status block.
`timescale 1ns/1ps
`include "acal_consts.vh"
module tb_adc_calibration_config_status;
    logic        REF_CLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic        ENG_FG_END, ENG_BG_HALTED;
    logic [11:0] AWADDR, ARADDR;
    logic [31:0] WDATA;
    logic [3:0]  WSTRB;
    wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, ENG_RST_N, CAL_VALUES_CLR;
    wire         FG_RUN, FG_OFFSET_RUN, BG_RUN, BG_OFFSET_RUN, IRQ;
    wire [1:0]   BRESP, RRESP;
    wire [31:0]  RDATA;
    wire [2:0]   CORE_PARKED, OFFSET_AVG, LINEARITY_AVG;
    int          miscompares, num_checks, cycles, n, seed;
    logic [33:0] rd_q[$];
    logic [1:0]  wr_q[$];
    logic [7:0]  d;

    acal_ctrl dut_u (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
        .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
        .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR),
        .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP),
        .RVALID(RVALID), .RREADY(RREADY), .ENG_FG_END(ENG_FG_END),
        .ENG_BG_HALTED(ENG_BG_HALTED), .ENG_RST_N(ENG_RST_N),
        .CAL_VALUES_CLR(CAL_VALUES_CLR), .FG_RUN(FG_RUN), .FG_OFFSET_RUN(FG_OFFSET_RUN),
        .BG_RUN(BG_RUN), .BG_OFFSET_RUN(BG_OFFSET_RUN), .CORE_PARKED(CORE_PARKED),
        .OFFSET_AVG(OFFSET_AVG), .LINEARITY_AVG(LINEARITY_AVG), .IRQ(IRQ));

    // ****************************************************************
    // Checking, bus tasks and closing report
    // ****************************************************************
    task automatic chk(input string nm, input logic [33:0] exp, input logic [33:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] v, input logic [1:0] er);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        @(posedge REF_CLK);
        wr_q.push_back(er);
        AWADDR  <= {idx, 2'b00};
        WDATA   <= {24'h00_0000, v};
        AWVALID <= 1'b1;
        WVALID  <= 1'b1;
        BREADY  <= 1'b1;
        do begin
            @(posedge REF_CLK);
            aw = aw && !AWREADY;
            w = w && !WREADY;
            AWVALID <= aw;
            WVALID  <= w;
        end while (aw || w);
        do @(posedge REF_CLK); while (!BVALID);
        BREADY <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] idx, input logic [7:0] ev, input logic [1:0] er);
        @(posedge REF_CLK);
        rd_q.push_back({er, 24'h00_0000, ev});
        ARADDR  <= {idx, 2'b00};
        ARVALID <= 1'b1;
        RREADY  <= 1'b1;
        do @(posedge REF_CLK); while (!ARREADY);
        ARVALID <= 1'b0;
        do @(posedge REF_CLK); while (!RVALID);
        RREADY <= 1'b0;
    endtask

    task automatic fg_pulse();
        @(posedge REF_CLK);
        ENG_FG_END <= 1'b1;
        @(posedge REF_CLK);
        ENG_FG_END <= 1'b0;
        @(posedge REF_CLK);
    endtask

    // Responses are matched against the oldest note left by the bus tasks.
    always @(posedge REF_CLK) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
        if (BVALID && BREADY) chk("write response", wr_q.pop_front(), BRESP);
        if (RVALID && RREADY) chk("read data", rd_q.pop_front(), {RRESP, RDATA});
    end

    initial begin
        REF_CLK = 1'b0;
        forever #10 REF_CLK = ~REF_CLK;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        seed = 82081;
        {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY} = 6'h00;
        {ENG_FG_END, ENG_BG_HALTED, AWADDR, ARADDR, WDATA} = 0;
        WSTRB = 4'h1;
        repeat (10) @(posedge REF_CLK);
        RST_N <= 1'b1;
        @(posedge REF_CLK);
        chk("offset avg", 3'h6, OFFSET_AVG);
        chk("linearity avg", 3'h1, LINEARITY_AVG);
        rd(`ACAL_IDX_CAL_EN, 8'h01, 2'h0);
        rd(`ACAL_IDX_MODE_CFG, 8'h01, 2'h0);
        rd(`ACAL_IDX_PARK_SEL, 8'h02, 2'h0);
        rd(`ACAL_IDX_AVG, 8'h61, 2'h0);
        rd(`ACAL_IDX_PIN_CFG, 8'h00, 2'h0);
        rd(`ACAL_IDX_STATUS, 8'h08, 2'h0);
        wr(`ACAL_IDX_STATUS, 8'h55, 2'h0);
        rd(`ACAL_IDX_STATUS, 8'h08, 2'h0);
        chk("fg run", 1'b1, FG_RUN);
        chk("fg offset", 1'b0, FG_OFFSET_RUN);
        fg_pulse();
        chk("parked", 3'h4, CORE_PARKED);
        rd(`ACAL_IDX_STATUS, 8'h13, 2'h0);
        rd(`ACAL_IDX_IRQ_STS, 8'h03, 2'h0);
        wr(`ACAL_IDX_IRQ_EN, 8'h01, 2'h0);
        repeat (2) @(posedge REF_CLK);
        chk("irq", 1'b1, IRQ);
        wr(`ACAL_IDX_IRQ_CLR, 8'h01, 2'h0);
        repeat (2) @(posedge REF_CLK);
        chk("irq", 1'b0, IRQ);
        rd(`ACAL_IDX_IRQ_STS, 8'h02, 2'h0);
        rd(10'h07F, 8'h00, 2'h2);
        wr(10'h07F, 8'hA5, 2'h2);
        for (n = 3; n >= 0; n--) begin
            wr(`ACAL_IDX_PARK_SEL, n[7:0], 2'h0);
            @(posedge REF_CLK);
            chk("parked", (n == 3) ? 34'h0 : 34'h1 << n, CORE_PARKED);
        end
        repeat (4) begin
            d = $random(seed) & 8'h77;
            wr(`ACAL_IDX_AVG, d, 2'h0);
            @(posedge REF_CLK);
            chk("offset avg", d[6:4], OFFSET_AVG);
            chk("linearity avg", d[2:0], LINEARITY_AVG);
            rd(`ACAL_IDX_AVG, d, 2'h0);
        end
        wr(`ACAL_IDX_CAL_EN, 8'h00, 2'h0);
        @(posedge REF_CLK);
        chk("engine reset", 1'b0, ENG_RST_N);
        rd(`ACAL_IDX_STATUS, 8'h00, 2'h0);
        wr(`ACAL_IDX_MODE_CFG, 8'h0F, 2'h0);
        wr(`ACAL_IDX_CAL_EN, 8'h01, 2'h0);
        for (n = 0; n < 50 && !FG_RUN; n++) @(posedge REF_CLK);
        chk("fg offset", 1'b1, FG_OFFSET_RUN);
        fg_pulse();
        chk("bg run", 1'b1, BG_RUN);
        chk("bg offset", 1'b1, BG_OFFSET_RUN);
        rd(`ACAL_IDX_STATUS, 8'h0D, 2'h0);
        ENG_BG_HALTED <= 1'b1;
        rd(`ACAL_IDX_STATUS, 8'h0F, 2'h0);
        ENG_BG_HALTED <= 1'b0;
        rd(`ACAL_IDX_STATUS, 8'h0D, 2'h0);
        wr(`ACAL_IDX_CAL_EN, 8'h00, 2'h0);
        wr(`ACAL_IDX_MODE_CFG, 8'h02, 2'h0);
        wr(`ACAL_IDX_CAL_EN, 8'h01, 2'h0);
        for (n = 0; n < 50 && !BG_RUN; n++) @(posedge REF_CLK);
        rd(`ACAL_IDX_STATUS, 8'h0D, 2'h0);
        wr(`ACAL_IDX_MODE_CFG, 8'h00, 2'h0);
        rd(`ACAL_IDX_STATUS, 8'h13, 2'h0);
        chk("parked", 3'h1, CORE_PARKED);
        complete_run();
    end
endmodule

bind acal_ctrl acal_ctrl_monitor mon_u (
    .REF_CLK(REF_CLK), .RST_N(RST_N), .ENG_FG_END(ENG_FG_END), .ENG_RST_N(ENG_RST_N),
    .CAL_VALUES_CLR(CAL_VALUES_CLR), .FG_RUN(FG_RUN), .FG_OFFSET_RUN(FG_OFFSET_RUN),
    .BG_RUN(BG_RUN), .BG_OFFSET_RUN(BG_OFFSET_RUN), .CORE_PARKED(CORE_PARKED),
    .OFFSET_AVG(OFFSET_AVG), .LINEARITY_AVG(LINEARITY_AVG));
